//--- src/hrsb_bridge.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "hrsb_defines.svh"

// Functional notes
// - Output report byte 0 bit 7 set stops periodic joystick sampling.
// - Byte 0 bits 2..0 give length 0..7; bits 6..3 sent as zero.
// - Output report: control byte then seven payload bytes for the sensor.
// - Each byte sent captures one byte received at the same time.
// - Input report: received count in byte 0, received bytes 1..7.
// - Write-only transactions still return an input report with the count.
// - Interface 0 carries joystick data, interface 1 the sensor reports.
// - Button becoming active raises remote wake-up to a suspended host.
// - Sensor interrupt assertion also raises remote wake-up.
// - Sensor select is open drain and frames each serial exchange.
// - Sensor interrupt input is monitored as a wake source.
// - Buttons are active low; pressed while input held low.
module hrsb_bridge
    import hrsb_pkg::*;
#(
    parameter int POLL_CYC = `HRSB_POLL_CYC,
    parameter int WAKE_CYC = `HRSB_WAKE_CYC
)
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  button_inputs_n_i,
    input  wire logic        sensor_int_i,
    input  wire logic        miso_i,
    output logic             sck_o,
    output logic             mosi_o,
    output logic             sensor_sel_n_o,
    output logic             sensor_sel_oe_o,
    output logic             remote_wake_o,
    output logic             joy_valid_o,
    output logic [55:0]      joy_data_o,
    output logic             irq_o
);
    // ***************************************************************
    // Pin synchronisers.
    // ***************************************************************
    logic [7:0] btn_s1_reg, btn_s2_reg, btn_prev_reg;
    logic       int_s1_reg, int_s2_reg, int_prev_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            btn_s1_reg   <= 8'hff;
            btn_s2_reg   <= 8'hff;
            btn_prev_reg <= 8'hff;
            int_s1_reg   <= 1'b0;
            int_s2_reg   <= 1'b0;
            int_prev_reg <= 1'b0;
        end else begin
            btn_s1_reg   <= button_inputs_n_i;
            btn_s2_reg   <= btn_s1_reg;
            btn_prev_reg <= btn_s2_reg;
            int_s1_reg   <= sensor_int_i;
            int_s2_reg   <= int_s1_reg;
            int_prev_reg <= int_s2_reg;
        end
    end

    logic [7:0] btn_press;
    logic       int_rise;
    assign btn_press = btn_prev_reg & ~btn_s2_reg;
    assign int_rise  = int_s2_reg & ~int_prev_reg;

    // ***************************************************************
    // Register file and report sequencing.
    // ***************************************************************
    logic        spi_start;
    logic [2:0]  spi_count;
    logic [55:0] spi_tx;
    logic        spi_busy, spi_done;
    logic [55:0] spi_rx;

    logic [63:0] out_rep_reg, out_rep_next;
    logic [63:0] in_rep_reg, in_rep_next;
    logic        inhibit_reg, inhibit_next;
    logic        wake_en_reg, wake_en_next;
    logic        suspend_reg, suspend_next;
    logic        pend_reg, pend_next;
    logic        joy_txn_reg, joy_txn_next;
    logic        rep_txn_reg, rep_txn_next;
    logic [3:0]  irq_stat_reg, irq_stat_next;
    logic [3:0]  irq_mask_reg, irq_mask_next;
    logic [31:0] poll_cnt_reg, poll_cnt_next;
    logic [31:0] rdata_next;
    logic        wake_event;
    logic        wake_issue;
    logic        acc;
    logic        wr;

    logic [55:0] pay_tx;
    for (genvar gi = 0; gi < 7; gi++) begin : g_pay
        assign pay_tx[55 - 8 * gi -: 8] = out_rep_reg[8 * gi + 8 +: 8];
    end
    assign acc = psel_i && penable_i;
    assign wr  = acc && pwrite_i;

    always_comb begin
        out_rep_next  = out_rep_reg;
        in_rep_next   = in_rep_reg;
        inhibit_next  = inhibit_reg;
        wake_en_next  = wake_en_reg;
        suspend_next  = suspend_reg;
        pend_next     = pend_reg;
        joy_txn_next  = joy_txn_reg;
        rep_txn_next  = rep_txn_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        poll_cnt_next = poll_cnt_reg;
        spi_start     = 1'b0;
        spi_count     = 3'd0;
        spi_tx        = '0;
        rdata_next    = 32'h0000_0000;
        if (wr) begin
            case (paddr_i)
                `HRSB_ADDR_CTRL: begin
                    wake_en_next = pwdata_i[`HRSB_CTRL_WAKE_EN];
                    suspend_next = pwdata_i[`HRSB_CTRL_SUSPEND];
                    if (pwdata_i[`HRSB_CTRL_START]) begin
                        pend_next = 1'b1;
                    end
                end
                `HRSB_ADDR_OUT_LO: out_rep_next[31:0]  = pwdata_i;
                `HRSB_ADDR_OUT_HI: out_rep_next[63:32] = pwdata_i;
                `HRSB_ADDR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata_i[3:0];
                `HRSB_ADDR_IRQ_MASK: irq_mask_next = pwdata_i[3:0];
                default: begin
                end
            endcase
        end
        if (psel_i && !pwrite_i) begin
            case (paddr_i)
                `HRSB_ADDR_CTRL: rdata_next = {29'h0, suspend_reg, wake_en_reg, pend_reg};
                `HRSB_ADDR_STATUS: rdata_next = {29'h0, inhibit_reg, rep_txn_reg, spi_busy};
                `HRSB_ADDR_OUT_LO: rdata_next = out_rep_reg[31:0];
                `HRSB_ADDR_OUT_HI: rdata_next = out_rep_reg[63:32];
                `HRSB_ADDR_IN_LO: rdata_next = in_rep_reg[31:0];
                `HRSB_ADDR_IN_HI: rdata_next = in_rep_reg[63:32];
                `HRSB_ADDR_IRQ_STAT: rdata_next = {28'h0, irq_stat_reg};
                `HRSB_ADDR_IRQ_MASK: rdata_next = {28'h0, irq_mask_reg};
                `HRSB_ADDR_BUTTONS: rdata_next = {24'h0, ~btn_s2_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (!inhibit_reg && poll_cnt_reg != 32'd0) begin
            poll_cnt_next = poll_cnt_reg - 32'd1;
        end
        if (!spi_busy && !joy_txn_reg && !rep_txn_reg) begin
            if (pend_reg) begin
                pend_next    = 1'b0;
                inhibit_next = out_rep_reg[`HRSB_FLAG_INHIBIT];
                spi_count    = out_rep_reg[`HRSB_CNT_MSB:0];
                spi_tx       = pay_tx;
                spi_start    = 1'b1;
                rep_txn_next = 1'b1;
            end else if (!inhibit_reg && poll_cnt_reg == 32'd0) begin
                poll_cnt_next = POLL_CYC;
                spi_count     = `HRSB_POLL_LEN;
                spi_tx        = {`HRSB_POLL_CMD, 48'h0};
                spi_start     = 1'b1;
                joy_txn_next  = 1'b1;
            end
        end
        if (spi_done && rep_txn_reg) begin
            rep_txn_next = 1'b0;
            in_rep_next  = {spi_rx, 5'h00, out_rep_reg[`HRSB_CNT_MSB:0]};
            irq_stat_next[`HRSB_IRQ_DONE] = 1'b1;
        end
        if (spi_done && joy_txn_reg) begin
            joy_txn_next = 1'b0;
        end
        if (wake_issue) begin
            irq_stat_next[`HRSB_IRQ_WAKE] = 1'b1;
        end
        if (int_rise) begin
            irq_stat_next[`HRSB_IRQ_SENSOR] = 1'b1;
        end
        if (|btn_press) begin
            irq_stat_next[`HRSB_IRQ_BUTTON] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            out_rep_reg  <= '0;
            in_rep_reg   <= '0;
            inhibit_reg  <= 1'b0;
            wake_en_reg  <= 1'b0;
            suspend_reg  <= 1'b0;
            pend_reg     <= 1'b0;
            joy_txn_reg  <= 1'b0;
            rep_txn_reg  <= 1'b0;
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            poll_cnt_reg <= 32'd0;
            prdata_o     <= 32'h0000_0000;
            pready_o     <= 1'b0;
            pslverr_o    <= 1'b0;
            irq_o        <= 1'b0;
            joy_valid_o  <= 1'b0;
            joy_data_o   <= '0;
        end else begin
            out_rep_reg  <= out_rep_next;
            in_rep_reg   <= in_rep_next;
            inhibit_reg  <= inhibit_next;
            wake_en_reg  <= wake_en_next;
            suspend_reg  <= suspend_next;
            pend_reg     <= pend_next;
            joy_txn_reg  <= joy_txn_next;
            rep_txn_reg  <= rep_txn_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            poll_cnt_reg <= poll_cnt_next;
            prdata_o     <= rdata_next;
            pready_o     <= psel_i && !pready_o;
            pslverr_o    <= 1'b0;
            irq_o        <= |(irq_stat_next & irq_mask_next);
            joy_valid_o  <= spi_done && joy_txn_reg;
            if (spi_done && joy_txn_reg) begin
                joy_data_o <= spi_rx;
            end
        end
    end

    // ***************************************************************
    // Remote wake-up signalling.
    // ***************************************************************
    hrsb_wake_state_type wk_state_reg, wk_state_next;
    logic [31:0]         wk_cnt_reg, wk_cnt_next;

    assign wake_event = (|btn_press) || int_rise;
    assign wake_issue = (wk_state_reg == WK_IDLE) && wake_event
                        && wake_en_reg && suspend_reg;

    always_comb begin
        wk_state_next = wk_state_reg;
        wk_cnt_next   = wk_cnt_reg;
        case (wk_state_reg)
            WK_IDLE: begin
                if (wake_issue) begin
                    wk_cnt_next   = WAKE_CYC;
                    wk_state_next = WK_SIGNAL;
                end
            end
            WK_SIGNAL: begin
                wk_cnt_next = wk_cnt_reg - 32'd1;
                if (wk_cnt_reg == 32'd1) begin
                    wk_state_next = WK_WAIT;
                end
            end
            WK_WAIT: begin
                if (!suspend_reg) begin
                    wk_state_next = WK_IDLE;
                end
            end
            default: begin
                wk_state_next = WK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wk_state_reg  <= WK_IDLE;
            wk_cnt_reg    <= 32'd0;
            remote_wake_o <= 1'b0;
        end else begin
            wk_state_reg  <= wk_state_next;
            wk_cnt_reg    <= wk_cnt_next;
            remote_wake_o <= (wk_state_next == WK_SIGNAL);
        end
    end

    // ***************************************************************
    // Serial engine; select pulls low only while enabled.
    // ***************************************************************
    logic sel_oe;

    hrsb_spi_engine u_spi (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .start_i (spi_start),
        .count_i (spi_count),
        .tx_i    (spi_tx),
        .miso_i  (miso_i),
        .sck_o   (sck_o),
        .mosi_o  (mosi_o),
        .cs_oe_o (sel_oe),
        .busy_o  (spi_busy),
        .done_o  (spi_done),
        .rx_o    (spi_rx)
    );

    assign sensor_sel_n_o  = 1'b0;
    assign sensor_sel_oe_o = sel_oe;
endmodule

//--- src/hrsb_defines.svh
`ifndef HRSB_DEFINES_SVH
`define HRSB_DEFINES_SVH

// APB register byte offsets.
`define HRSB_ADDR_CTRL      12'h000
`define HRSB_ADDR_STATUS    12'h004
`define HRSB_ADDR_OUT_LO    12'h008
`define HRSB_ADDR_OUT_HI    12'h00c
`define HRSB_ADDR_IN_LO     12'h010
`define HRSB_ADDR_IN_HI     12'h014
`define HRSB_ADDR_IRQ_STAT  12'h018
`define HRSB_ADDR_IRQ_MASK  12'h01c
`define HRSB_ADDR_BUTTONS   12'h020

// Control register fields.
`define HRSB_CTRL_START     0
`define HRSB_CTRL_WAKE_EN   1
`define HRSB_CTRL_SUSPEND   2

// Output report control byte fields.
`define HRSB_FLAG_INHIBIT   7
`define HRSB_CNT_MSB        2

// Interrupt status bits.
`define HRSB_IRQ_DONE       0
`define HRSB_IRQ_WAKE       1
`define HRSB_IRQ_SENSOR     2
`define HRSB_IRQ_BUTTON     3
`define HRSB_IRQ_W          4

// Timing.
`define HRSB_CLK_HZ         20000000
`define HRSB_SCK_HALF       8'd4
`define HRSB_POLL_US        8000
`define HRSB_POLL_CYC       ((`HRSB_CLK_HZ / 1000000) * `HRSB_POLL_US)
`define HRSB_WAKE_US        10000
`define HRSB_WAKE_CYC       ((`HRSB_CLK_HZ / 1000000) * `HRSB_WAKE_US)
`define HRSB_POLL_LEN       3'd7
`define HRSB_POLL_CMD       8'h82

`endif

//--- src/hrsb_pkg.sv
package hrsb_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEL,
        ST_LOW,
        ST_HIGH,
        ST_DONE
    } hrsb_spi_state_type;
    typedef enum logic [1:0] {
        WK_IDLE,
        WK_SIGNAL,
        WK_WAIT
    } hrsb_wake_state_type;
endpackage

//--- src/hrsb_spi_engine.sv
`timescale 1ns/1ps
`include "hrsb_defines.svh"

// ***************************************************************
// Full-duplex byte shifter, mode 0, select held over a whole burst.
// ***************************************************************
module hrsb_spi_engine
    import hrsb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        start_i,
    input  wire logic [2:0]  count_i,
    input  wire logic [55:0] tx_i,
    input  wire logic        miso_i,
    output logic             sck_o,
    output logic             mosi_o,
    output logic             cs_oe_o,
    output logic             busy_o,
    output logic             done_o,
    output logic [55:0]      rx_o
);
    hrsb_spi_state_type state_reg, state_next;
    logic [7:0]  div_reg, div_next;
    logic [2:0]  bit_reg, bit_next;
    logic [2:0]  byte_reg, byte_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic [55:0] tx_reg, tx_next;
    logic [55:0] rx_reg, rx_next;
    logic        miso_s1_reg, miso_s2_reg;

    always_comb begin
        state_next = state_reg;
        div_next   = div_reg;
        bit_next   = bit_reg;
        byte_next  = byte_reg;
        cnt_next   = cnt_reg;
        tx_next    = tx_reg;
        rx_next    = rx_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_i) begin
                    cnt_next   = count_i;
                    tx_next    = tx_i;
                    rx_next    = '0;
                    bit_next   = 3'd0;
                    byte_next  = 3'd0;
                    div_next   = 8'd0;
                    state_next = (count_i == 3'd0) ? ST_DONE : ST_SEL;
                end
            end
            ST_SEL: begin
                div_next = div_reg + 8'd1;
                if (div_reg == `HRSB_SCK_HALF) begin
                    div_next   = 8'd0;
                    state_next = ST_LOW;
                end
            end
            ST_LOW: begin
                div_next = div_reg + 8'd1;
                if (div_reg == `HRSB_SCK_HALF) begin
                    div_next   = 8'd0;
                    rx_next[{byte_reg, ~bit_reg}] = miso_s2_reg;
                    state_next = ST_HIGH;
                end
            end
            ST_HIGH: begin
                div_next = div_reg + 8'd1;
                if (div_reg == `HRSB_SCK_HALF) begin
                    div_next   = 8'd0;
                    tx_next    = {tx_reg[54:0], 1'b0};
                    bit_next   = bit_reg + 3'd1;
                    state_next = ST_LOW;
                    if (bit_reg == 3'd7) begin
                        byte_next = byte_reg + 3'd1;
                        if (byte_reg + 3'd1 == cnt_reg) begin
                            state_next = ST_DONE;
                        end
                    end
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg   <= ST_IDLE;
            div_reg     <= 8'd0;
            bit_reg     <= 3'd0;
            byte_reg    <= 3'd0;
            cnt_reg     <= 3'd0;
            tx_reg      <= '0;
            rx_reg      <= '0;
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
            sck_o       <= 1'b0;
            mosi_o      <= 1'b0;
            cs_oe_o     <= 1'b0;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            rx_o        <= '0;
        end else begin
            state_reg   <= state_next;
            div_reg     <= div_next;
            bit_reg     <= bit_next;
            byte_reg    <= byte_next;
            cnt_reg     <= cnt_next;
            tx_reg      <= tx_next;
            rx_reg      <= rx_next;
            miso_s1_reg <= miso_i;
            miso_s2_reg <= miso_s1_reg;
            sck_o       <= (state_next == ST_HIGH);
            mosi_o      <= tx_next[55];
            cs_oe_o     <= (state_next == ST_SEL) || (state_next == ST_LOW)
                           || (state_next == ST_HIGH);
            busy_o      <= (state_next != ST_IDLE);
            done_o      <= (state_reg == ST_DONE);
            if (state_reg == ST_DONE) begin
                rx_o <= rx_reg;
            end
        end
    end
endmodule

//--- test/hrsb_bridge_asserts.sv
`timescale 1ns/1ps
// **************************************
// Port checker for the sensor bridge.
// **************************************
module hrsb_bridge_asserts #(
    parameter int WAKE_CYC = 50
)
(
    input logic clk_i,
    input logic reset_i,
    input logic psel_i,
    input logic penable_i,
    input logic pready_o,
    input logic pslverr_o,
    input logic sck_o,
    input logic mosi_o,
    input logic sensor_sel_n_o,
    input logic sensor_sel_oe_o,
    input logic remote_wake_o,
    input logic joy_valid_o
);
    logic        sck_prev_reg;
    logic [5:0]  edges_reg;
    logic [5:0]  edges_next;
    logic [31:0] wake_cnt_reg;
    logic [31:0] wake_cnt_next;
    // Rising clock edges inside one select frame, and length of the wake pulse.
    always_comb begin
        edges_next    = sensor_sel_oe_o ? edges_reg + {5'h0, sck_o & ~sck_prev_reg} : 6'h0;
        wake_cnt_next = remote_wake_o ? wake_cnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sck_prev_reg <= 1'b0;
            edges_reg    <= 6'h0;
            wake_cnt_reg <= 32'h0;
        end else begin
            sck_prev_reg <= sck_o;
            edges_reg    <= edges_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_sck_high;
        sck_o [*5] ##1 !sck_o;
    endsequence
    a_ready_on_time: assert property (s_setup |=> pready_o)
        else $error("pready late");
    a_ready_cause: assert property (pready_o |-> psel_i && penable_i ##1 !pready_o)
        else $error("pready without access");
    a_no_slave_err: assert property (!pslverr_o)
        else $error("pslverr raised");
    a_sel_open_drain: assert property (sensor_sel_n_o == 1'b0)
        else $error("select drives high");
    a_sck_in_frame: assert property (sck_o |-> sensor_sel_oe_o)
        else $error("clock outside select");
    a_sck_half_period: assert property ($rose(sck_o) |-> s_sck_high)
        else $error("clock high phase wrong");
    a_mosi_steady: assert property (sck_o && $past(sck_o) |-> $stable(mosi_o))
        else $error("mosi moved while clock high");
    a_whole_bytes: assert property ($fell(sensor_sel_oe_o) |-> edges_reg != 6'h0 && edges_reg[2:0] == 3'h0)
        else $error("frame not whole bytes");
    a_wake_length: assert property ($fell(remote_wake_o) |-> wake_cnt_reg == 32'(WAKE_CYC))
        else $error("wake pulse length wrong");
    a_joy_pulse: assert property (joy_valid_o |=> !joy_valid_o)
        else $error("joystick valid too long");
endmodule

bind hrsb_bridge hrsb_bridge_asserts #(.WAKE_CYC(WAKE_CYC)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sck_o(sck_o), .mosi_o(mosi_o),
    .sensor_sel_n_o(sensor_sel_n_o), .sensor_sel_oe_o(sensor_sel_oe_o),
    .remote_wake_o(remote_wake_o), .joy_valid_o(joy_valid_o));

//--- test/hrsb_sensor_model.sv
`timescale 1ns/1ps
// **************************************************
// Sensor side of the serial link, mode 0, MSB first.
// **************************************************
module hrsb_sensor_model (
    input  wire logic        sck_i,
    input  wire logic        mosi_i,
    input  wire logic        sel_n_i,
    output logic             miso_o,
    output logic [55:0]      got_o,
    output logic [3:0]       nbytes_o
);
    int         bits;
    logic [7:0] resp;
    initial begin
        bits     = 0;
        miso_o   = 1'b0;
        got_o    = 56'h0;
        nbytes_o = 4'h0;
    end
    // Byte k of a frame answers 8'h90 + k; its first bit is ready before the first edge.
    always @(negedge sel_n_i) begin
        bits   = 0;
        got_o  = 56'h0;
        miso_o = 1'b1;
    end
    // A released data line shows no trustworthy value.
    always @(posedge sel_n_i) begin
        nbytes_o = 4'(bits / 8);
        miso_o   = ~miso_o;
    end
    always @(posedge sck_i) begin
        if (!sel_n_i) begin
            got_o = {got_o[54:0], mosi_i};
            bits  = bits + 1;
        end
    end
    always @(negedge sck_i) begin
        if (!sel_n_i) begin
            resp   = 8'h90 + 8'(bits / 8);
            miso_o = resp[7 - bits % 8];
        end
    end
endmodule

//--- test/hrsb_bridge_tb_top.sv
`timescale 1ns/1ps
`include "hrsb_defines.svh"
module hrsb_bridge_tb_top;
    localparam int POLL = 200;
    typedef struct {string name; logic [31:0] exp; logic [31:0] msk;} hrsb_note_type;
    hrsb_note_type notes[$];
    hrsb_note_type nt;
    logic clk_i, reset_i, psel_i, penable_i, pwrite_i, sensor_int_i, miso_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [7:0]  btn;
    logic pready_o, pslverr_o, sck_o, mosi_o, sel_n_o, sel_oe_o, remote_wake_o, joy_valid_o, irq_o;
    logic [55:0] joy_data_o, got;
    logic [3:0]  nb;
    wire         sel_wire_n = sel_oe_o ? sel_n_o : 1'b1;
    int          compares, miscompares, cyc, jcount, j0, seed;

    hrsb_bridge #(.POLL_CYC(POLL), .WAKE_CYC(50)) u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .button_inputs_n_i(btn),
        .sensor_int_i(sensor_int_i), .miso_i(miso_i), .sck_o(sck_o), .mosi_o(mosi_o),
        .sensor_sel_n_o(sel_n_o), .sensor_sel_oe_o(sel_oe_o), .remote_wake_o(remote_wake_o),
        .joy_valid_o(joy_valid_o), .joy_data_o(joy_data_o), .irq_o(irq_o));
    hrsb_sensor_model u_sensor (.sck_i(sck_o), .mosi_i(mosi_o), .sel_n_i(sel_wire_n),
        .miso_o(miso_i), .got_o(got), .nbytes_o(nb));

    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (joy_valid_o === 1'b1) jcount++;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end
    // Each read answer is matched against the oldest expectation noted by the driver.
    always @(posedge clk_i) begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            check(nt.name, {32'h0, prdata_o & nt.msk}, {32'h0, nt.exp & nt.msk});
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= addr;
        pwdata_i <= data;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask
    task automatic rd(input string name, input logic [11:0] addr, input logic [31:0] exp,
                      input logic [31:0] msk);
        notes.push_back('{name, exp, msk});
        apb(1'b0, addr, 32'h0);
    endtask
    task automatic wait_for(input int sel, input int lim);
        int n;
        n = 0;
        while (n < lim && (sel == 0 ? irq_o : sel == 1 ? remote_wake_o : jcount != j0) !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic xfer(input logic inh, input int n);
        logic [7:0]  pay [1:7];
        logic [63:0] ein, emsk, eout;
        for (int k = 1; k <= 7; k++) pay[k] = (k <= n) ? 8'($random(seed)) : 8'h0;
        // The first byte names a register to be read, so no calibration value is written.
        pay[1][7] = (n > 0);
        ein  = {56'h0, 8'(n)};
        emsk = 64'hff;
        eout = 64'h0;
        for (int k = 1; k <= n; k++) begin
            ein[8*k +: 8]  = 8'h90 + 8'(k - 1);
            emsk[8*k +: 8] = 8'hff;
            eout           = {eout[55:0], pay[k]};
        end
        wr(`HRSB_ADDR_OUT_LO, {pay[3], pay[2], pay[1], inh, 4'h0, 3'(n)});
        wr(`HRSB_ADDR_OUT_HI, {pay[7], pay[6], pay[5], pay[4]});
        wr(`HRSB_ADDR_CTRL, 32'h1);
        wait_for(0, 2000);
        check("done irq", {63'h0, irq_o}, 64'h1);
        if (n > 0) begin
            check("mosi bytes", {8'h0, got}, eout);
            check("byte count", {60'h0, nb}, 64'(n));
        end
        rd("in lo", `HRSB_ADDR_IN_LO, ein[31:0], emsk[31:0]);
        rd("in hi", `HRSB_ADDR_IN_HI, ein[63:32], emsk[63:32]);
        wr(`HRSB_ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_i);
        check("irq cleared", {63'h0, irq_o}, 64'h0);
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        {clk_i, psel_i, penable_i, pwrite_i, sensor_int_i} = 5'h0;
        {paddr_i, pwdata_i} = 44'h0;
        reset_i = 1'b1;
        btn     = 8'hff;
        seed    = 32'hcb97;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rd("unmapped", 12'h024, 32'h0, 32'hffffffff);
        wr(12'h024, 32'hffffffff);
        rd("unmapped", 12'h024, 32'h0, 32'hffffffff);
        rd("mask reset", `HRSB_ADDR_IRQ_MASK, 32'h0, 32'hffffffff);
        wr(`HRSB_ADDR_IRQ_MASK, 32'h1);
        $display("test registers done");
        xfer(1'b1, 0);
        rd("inhibit", `HRSB_ADDR_STATUS, 32'h4, 32'h4);
        j0 = jcount;
        repeat (3 * POLL) @(posedge clk_i);
        check("no polls", 64'(jcount - j0), 64'h0);
        $display("test inhibit done");
        for (int n = 1; n <= 7; n++) xfer(1'b1, n);
        $display("test transfers done");
        xfer(1'b0, 0);
        j0 = jcount;
        wait_for(2, 3 * POLL);
        check("polls resume", {63'h0, jcount != j0}, 64'h1);
        $display("test resume done");
        wr(`HRSB_ADDR_CTRL, 32'h4);
        btn <= 8'hdf;
        repeat (20) @(posedge clk_i);
        check("wake disabled", {63'h0, remote_wake_o}, 64'h0);
        btn <= 8'hff;
        wr(`HRSB_ADDR_CTRL, 32'h6);
        btn <= 8'hfe;
        wait_for(1, 20);
        check("button wake", {63'h0, remote_wake_o}, 64'h1);
        rd("buttons", `HRSB_ADDR_BUTTONS, 32'h1, 32'hff);
        check("irq masked", {63'h0, irq_o}, 64'h0);
        repeat (60) @(posedge clk_i);
        btn <= 8'hff;
        wr(`HRSB_ADDR_CTRL, 32'h2);
        wr(`HRSB_ADDR_CTRL, 32'h6);
        sensor_int_i <= 1'b1;
        wait_for(1, 20);
        check("sensor wake", {63'h0, remote_wake_o}, 64'h1);
        sensor_int_i <= 1'b0;
        wr(`HRSB_ADDR_IRQ_MASK, 32'hf);
        wait_for(0, 10);
        check("irq unmasked", {63'h0, irq_o}, 64'h1);
        rd("events", `HRSB_ADDR_IRQ_STAT, 32'he, 32'he);
        wr(`HRSB_ADDR_IRQ_STAT, 32'hf);
        repeat (2) @(posedge clk_i);
        check("irq cleared", {63'h0, irq_o}, 64'h0);
        $display("test wake done");
        results();
    end
endmodule
